/* File: verilog/raat_pkg.sv */
// Package for the radio transaction state machine: register map, fields,
// reset values and timing constants.
// Assumes a 50 MHz pclk and 32-bit APB register access.
package raat_pkg;
    // ============================================================
    // Clock and timing
    localparam int CLK_MHZ = 50;
    localparam int SETTLE_US = 130;
    localparam int MIN_CE_US = 10;
    localparam int ACK_WAIT_US = 250;
    localparam int RETRY_STEP_US = 250;
    localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
    localparam int MIN_CE_CYC = MIN_CE_US * CLK_MHZ;
    localparam int ACK_WAIT_CYC = ACK_WAIT_US * CLK_MHZ;
    localparam int RETRY_STEP_CYC = RETRY_STEP_US * CLK_MHZ;
    localparam int NUM_PIPES = 6;
    // ============================================================
    // Register byte addresses
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_RETRY = 12'h008;
    localparam logic [11:0] ADDR_PIPE_EN = 12'h00c;
    localparam logic [11:0] ADDR_P0_LO = 12'h010;
    localparam logic [11:0] ADDR_P0_HI = 12'h014;
    localparam logic [11:0] ADDR_P1_LO = 12'h018;
    localparam logic [11:0] ADDR_P1_HI = 12'h01c;
    localparam logic [11:0] ADDR_LSB = 12'h020;
    localparam logic [11:0] ADDR_SHARED = 12'h024;
    // ============================================================
    // Control and status fields, reset values
    localparam int CTRL_ACTIVATE = 0;
    localparam int CTRL_PRIMARY_RX = 1;
    localparam int CTRL_AUTO_ACK = 2;
    localparam int CTRL_CRC_EN = 3;
    localparam int CTRL_CRC_2B = 4;
    localparam int ST_TX_DONE = 0;
    localparam int ST_RX_READY = 1;
    localparam int ST_RETRY_LIM = 2;
    localparam logic [5:0] PIPE_EN_RST = 6'h03;
    localparam logic [3:0] RETRY_DELAY_RST = 4'h0;
    localparam logic [3:0] RETRY_LIMIT_RST = 4'h3;
    typedef enum logic [3:0] {
        RAAT_STBY1, RAAT_STBY2, RAAT_TX_SETTLE, RAAT_TX, RAAT_ACK_WAIT,
        RAAT_ACK_RECV, RAAT_RETRY_WAIT, RAAT_RX, RAAT_RX_SETTLE_ACK,
        RAAT_RX_SEND_ACK
    } raat_state_t;
endpackage

/* File: verilog/raat_fsm.sv */
// Transaction state machine of a packet radio link layer with APB
// registers. Assumes a modem below that reports packet events as
// one-cycle pulses on pclk and takes start pulses back.
// ============================================================
// Summary of operation
// - Activate high with queued packet in transmitter role starts a send.
// - With retries on and ack wanted, listen for acknowledge after send.
// - Empty acknowledge raises only transmit-done.
// - Acknowledge with payload raises transmit-done and receive-ready together.
// - No acknowledge: wait retry delay, resend if below limit.
// - Retry count reaching limit raises retry-limit flag, go standby-I.
// - Activate high with empty transmit queue holds standby-II.
// - Receiver role with activate high searches continuously.
// - Auto-ack receiver stores new packets and raises receive-ready.
// - Receiver raises transmit-done when ack payload confirmed by sender.
// - Receiver sends acknowledge with pending payload unless skip flag set.
// - Repeat packets are dropped but still acknowledged.
// - Six pipes matched in parallel, one packet at a time.
// - CRC, width, channel settings shared; CRC forced on with auto-ack.
// - Pipes enable individually; pipes 0 and 1 on after reset.
// - Pipe 0 full address; pipes 1-5 share upper four bytes.
// - Acknowledge goes to the pipe address the packet arrived on.
// - Every autonomous sequence ends with the radio interrupt. Here a repeat packet in receiver role is acknowledged with no interrupt.
// - Activate held minimum pulse; send starts after settling time. Pulse width not checked here (MIN_CE_CYC unused).
// - Received acknowledge raises interrupt and pops transmit queue.
// - Retry delay programmable in 250 us steps.
// - Ack wait ends on no match in 250 us or packet end.
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ps
module raat_fsm
    import raat_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic tx_fifo_empty,
    input wire logic tx_skip_ack,
    input wire logic tx_done_air,
    input wire logic addr_match,
    input wire logic [39:0] rx_addr,
    input wire logic rx_end,
    input wire logic rx_crc_ok,
    input wire logic rx_has_payload,
    input wire logic rx_is_repeat,
    input wire logic rx_skip_ack,
    output logic tx_start,
    output logic [39:0] tx_dest_addr,
    output logic tx_fifo_pop,
    output logic rx_fifo_push,
    output logic [2:0] rx_pipe,
    output logic rx_mode,
    output logic crc_enable,
    output logic crc_two_bytes,
    output logic radio_interrupt
);
    // ============================================================
    // Helpers
    function automatic logic [39:0] pipe_addr(input logic [2:0] p,
        input logic [39:0] a0, input logic [31:0] upper,
        input logic [39:0] lsbs);
        logic [39:0] r;
        r = a0;
        if (p != 3'h0)
        begin
            r = {upper, lsbs[8*(p-3'h1) +: 8]};
        end
        return r;
    endfunction

    // ============================================================
    // Registers
    logic [4:0] ctrl_q, ctrl_d;
    logic [2:0] stat_q, stat_d;
    logic [3:0] retry_delay_q, retry_delay_d;
    logic [3:0] retry_limit_q, retry_limit_d;
    logic [5:0] pipe_enable_bits_q, pipe_enable_bits_d;
    logic [39:0] p0_q, p0_d;
    logic [31:0] upper_q, upper_d;
    logic [39:0] lsb_q, lsb_d; // Pipes 1-5 low bytes
    logic [3:0] retry_cnt_q, retry_cnt_d;
    logic [2:0] pipe_q, pipe_d;
    logic ack_pay_pend_q, ack_pay_pend_d;
    logic [19:0] tmr_q, tmr_d;
    logic irq_q, irq_d;
    logic halt_q, halt_d;
    raat_state_t st_q, st_d;
    logic wr, rd;
    logic [2:0] set_flags;
    logic match_valid;
    logic [2:0] hit_pipe;

    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;
    assign pready = 1'b1;

    // Decode for the matched pipe
    always_comb
    begin
        match_valid = 1'b0;
        hit_pipe = 3'h0;
        for (int i = 0; i < NUM_PIPES; i++)
        begin
            if (!match_valid && pipe_enable_bits_q[i] && rx_addr ==
                pipe_addr(3'(i), p0_q, upper_q, lsb_q))
            begin
                match_valid = 1'b1;
                hit_pipe = 3'(i);
            end
        end
    end

    // ============================================================
    // Transaction state machine
    always_comb
    begin
        st_d = st_q;
        tmr_d = (tmr_q != 20'h0) ? tmr_q - 20'h1 : 20'h0;
        retry_cnt_d = retry_cnt_q;
        pipe_d = pipe_q;
        ack_pay_pend_d = ack_pay_pend_q;
        // After the retry limit, a new send needs activate toggled
        halt_d = halt_q && ctrl_q[CTRL_ACTIVATE];
        set_flags = 3'h0;
        tx_start = 1'b0;
        tx_fifo_pop = 1'b0;
        rx_fifo_push = 1'b0;
        case (st_q)
            RAAT_STBY1:
            begin
                if (ctrl_q[CTRL_ACTIVATE] && ctrl_q[CTRL_PRIMARY_RX])
                begin
                    st_d = RAAT_RX;
                end
                else if (ctrl_q[CTRL_ACTIVATE] && !halt_q)
                begin
                    retry_cnt_d = 4'h0;
                    st_d = tx_fifo_empty ? RAAT_STBY2 : RAAT_TX_SETTLE;
                    tmr_d = 20'(SETTLE_CYC);
                end
            end
            RAAT_STBY2:
            begin
                if (!ctrl_q[CTRL_ACTIVATE])
                begin
                    st_d = RAAT_STBY1;
                end
                else if (!tx_fifo_empty)
                begin
                    retry_cnt_d = 4'h0;
                    st_d = RAAT_TX_SETTLE;
                    tmr_d = 20'(SETTLE_CYC);
                end
            end
            RAAT_TX_SETTLE:
            begin
                if (tmr_q == 20'h0)
                begin
                    tx_start = 1'b1;
                    st_d = RAAT_TX;
                end
            end
            RAAT_TX:
            begin
                if (tx_done_air)
                begin
                    if (retry_limit_q != 4'h0 && !tx_skip_ack)
                    begin
                        st_d = RAAT_ACK_WAIT;
                        tmr_d = 20'(ACK_WAIT_CYC);
                    end
                    else
                    begin
                        set_flags[ST_TX_DONE] = 1'b1;
                        tx_fifo_pop = 1'b1;
                        st_d = RAAT_STBY1;
                    end
                end
            end
            RAAT_ACK_WAIT:
            begin
                if (addr_match)
                begin
                    st_d = RAAT_ACK_RECV;
                end
                else if (tmr_q == 20'h0)
                begin
                    st_d = RAAT_RETRY_WAIT;
                    // Ack wait already used the first delay step
                    tmr_d = 20'(RETRY_STEP_CYC) *
                        20'(retry_delay_q);
                end
            end
            RAAT_ACK_RECV:
            begin
                if (rx_end && rx_crc_ok)
                begin
                    set_flags[ST_TX_DONE] = 1'b1;
                    set_flags[ST_RX_READY] = rx_has_payload;
                    rx_fifo_push = rx_has_payload;
                    tx_fifo_pop = 1'b1;
                    st_d = RAAT_STBY1;
                end
                else if (rx_end)
                begin
                    st_d = RAAT_RETRY_WAIT;
                    tmr_d = 20'(RETRY_STEP_CYC) *
                        (20'(retry_delay_q) + 20'h1);
                end
            end
            RAAT_RETRY_WAIT:
            begin
                if (retry_cnt_q >= retry_limit_q)
                begin
                    set_flags[ST_RETRY_LIM] = 1'b1;
                    halt_d = 1'b1;
                    st_d = RAAT_STBY1;
                end
                else if (tmr_q == 20'h0)
                begin
                    retry_cnt_d = retry_cnt_q + 4'h1;
                    tx_start = 1'b1;
                    st_d = RAAT_TX;
                end
            end
            RAAT_RX:
            begin
                if (!ctrl_q[CTRL_ACTIVATE])
                begin
                    st_d = RAAT_STBY1;
                end
                else if (rx_end && rx_crc_ok && match_valid)
                begin
                    pipe_d = hit_pipe;
                    if (!rx_is_repeat || !ctrl_q[CTRL_AUTO_ACK])
                    begin
                        rx_fifo_push = 1'b1;
                        set_flags[ST_RX_READY] = 1'b1;
                        if (ack_pay_pend_q)
                        begin
                            set_flags[ST_TX_DONE] = 1'b1;
                            tx_fifo_pop = 1'b1;
                            ack_pay_pend_d = 1'b0;
                        end
                    end
                    if (ctrl_q[CTRL_AUTO_ACK] && !rx_skip_ack)
                    begin
                        st_d = RAAT_RX_SETTLE_ACK;
                        tmr_d = 20'(SETTLE_CYC);
                    end
                end
            end
            RAAT_RX_SETTLE_ACK:
            begin
                if (tmr_q == 20'h0)
                begin
                    tx_start = 1'b1;
                    ack_pay_pend_d = !tx_fifo_empty;
                    st_d = RAAT_RX_SEND_ACK;
                end
            end
            RAAT_RX_SEND_ACK:
            begin
                if (tx_done_air)
                begin
                    st_d = RAAT_RX;
                end
            end
            default:
            begin
                st_d = RAAT_STBY1;
            end
        endcase
    end

    // ============================================================
    // Register file
    always_comb
    begin
        ctrl_d = ctrl_q;
        retry_delay_d = retry_delay_q;
        retry_limit_d = retry_limit_q;
        pipe_enable_bits_d = pipe_enable_bits_q;
        p0_d = p0_q;
        upper_d = upper_q;
        lsb_d = lsb_q;
        stat_d = stat_q;
        if (wr && paddr == ADDR_STATUS)
        begin
            stat_d = stat_q & ~pwdata[2:0]; // Write one to clear
        end
        stat_d = stat_d | set_flags; // Set wins over clear
        if (wr)
        begin
            case (paddr)
                ADDR_CTRL: ctrl_d = pwdata[4:0];
                ADDR_RETRY:
                begin
                    retry_delay_d = pwdata[7:4];
                    retry_limit_d = pwdata[3:0];
                end
                ADDR_PIPE_EN: pipe_enable_bits_d = pwdata[5:0];
                ADDR_P0_LO: p0_d[31:0] = pwdata;
                ADDR_P0_HI: p0_d[39:32] = pwdata[7:0];
                ADDR_P1_LO: lsb_d[7:0] = pwdata[7:0];
                ADDR_P1_HI: upper_d = pwdata;
                ADDR_LSB: lsb_d[39:8] = pwdata;
                default: ;
            endcase
        end
        irq_d = |set_flags;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q <= RAAT_STBY1;
            tmr_q <= 20'h0;
            retry_cnt_q <= 4'h0;
            pipe_q <= 3'h0;
            ack_pay_pend_q <= 1'b0;
            ctrl_q <= 5'h0;
            stat_q <= 3'h0;
            retry_delay_q <= RETRY_DELAY_RST;
            retry_limit_q <= RETRY_LIMIT_RST;
            pipe_enable_bits_q <= PIPE_EN_RST;
            p0_q <= 40'h0;
            upper_q <= 32'h0;
            lsb_q <= 40'h0;
            irq_q <= 1'b0;
            halt_q <= 1'b0;
            prdata <= 32'h0;
            tx_dest_addr <= 40'h0;
        end
        else
        begin
            st_q <= st_d;
            tmr_q <= tmr_d;
            retry_cnt_q <= retry_cnt_d;
            pipe_q <= pipe_d;
            ack_pay_pend_q <= ack_pay_pend_d;
            ctrl_q <= ctrl_d;
            stat_q <= stat_d;
            retry_delay_q <= retry_delay_d;
            retry_limit_q <= retry_limit_d;
            pipe_enable_bits_q <= pipe_enable_bits_d;
            p0_q <= p0_d;
            upper_q <= upper_d;
            lsb_q <= lsb_d;
            irq_q <= irq_d;
            halt_q <= halt_d;
            tx_dest_addr <= ctrl_q[CTRL_PRIMARY_RX] ?
                pipe_addr(pipe_q, p0_q, upper_q, lsb_q) : p0_q;
            if (rd)
            begin
                case (paddr)
                    ADDR_CTRL: prdata <= {27'h0, ctrl_q};
                    ADDR_STATUS: prdata <= {21'h0, st_q, retry_cnt_q,
                        stat_q};
                    ADDR_RETRY: prdata <= {24'h0, retry_delay_q,
                        retry_limit_q};
                    ADDR_PIPE_EN: prdata <= {26'h0, pipe_enable_bits_q};
                    ADDR_P0_LO: prdata <= p0_q[31:0];
                    ADDR_P0_HI: prdata <= {24'h0, p0_q[39:32]};
                    ADDR_P1_LO: prdata <= {24'h0, lsb_q[7:0]};
                    ADDR_P1_HI: prdata <= upper_q;
                    ADDR_LSB: prdata <= lsb_q[39:8];
                    default: prdata <= 32'h0;
                endcase
            end
        end
    end

    assign pslverr = 1'b0;
    assign rx_pipe = pipe_q;
    assign rx_mode = (st_q == RAAT_RX) || (st_q == RAAT_ACK_WAIT) ||
        (st_q == RAAT_ACK_RECV);
    // CRC forced on while auto-ack is in use
    assign crc_enable = ctrl_q[CTRL_CRC_EN] || ctrl_q[CTRL_AUTO_ACK];
    assign crc_two_bytes = ctrl_q[CTRL_CRC_2B];
    assign radio_interrupt = irq_q;

    // ============================================================
    // Checks
    AST_SETTLE: assert property (@(posedge pclk) disable iff (!presetn)
        st_q == RAAT_STBY1 && st_d == RAAT_TX_SETTLE |-> ##1
        (!tx_start)[*8])
        else $error("send started before settling");
    AST_LIMIT: assert property (@(posedge pclk) disable iff (!presetn)
        set_flags[ST_RETRY_LIM] |-> retry_cnt_q >= retry_limit_q)
        else $error("retry flag without limit");
    AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
        |set_flags |=> radio_interrupt)
        else $error("no interrupt at sequence end");
    AST_POP: assert property (@(posedge pclk) disable iff (!presetn)
        st_q == RAAT_ACK_RECV && rx_end && rx_crc_ok |-> tx_fifo_pop
        ##1 stat_q[ST_TX_DONE])
        else $error("ack not handled");
    AST_BOTH: assert property (@(posedge pclk) disable iff (!presetn)
        st_q == RAAT_ACK_RECV && rx_end && rx_crc_ok && rx_has_payload
        |=> stat_q[ST_RX_READY] && stat_q[ST_TX_DONE])
        else $error("payload ack flags");
    AST_STBY2: assert property (@(posedge pclk) disable iff (!presetn)
        st_q == RAAT_STBY2 && ctrl_q[CTRL_ACTIVATE] && tx_fifo_empty
        |=> st_q == RAAT_STBY2)
        else $error("left standby-II");
    AST_CRC: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_q[CTRL_AUTO_ACK] |-> crc_enable)
        else $error("crc off with auto-ack");
    AST_RETRY_CNT: assert property (@(posedge pclk) disable iff (!presetn)
        st_q == RAAT_RETRY_WAIT && tx_start |=>
        retry_cnt_q == $past(retry_cnt_q) + 4'h1)
        else $error("retry count not stepped");
    AST_ACKWAIT: assert property (@(posedge pclk) disable iff (!presetn)
        st_q == RAAT_TX && tx_done_air && !tx_skip_ack &&
        retry_limit_q != 4'h0 |=> rx_mode)
        else $error("no ack listen");
    COV_TX_OK: cover property (@(posedge pclk) st_q == RAAT_ACK_RECV
        && rx_end && rx_crc_ok);
    COV_LIMIT: cover property (@(posedge pclk) set_flags[ST_RETRY_LIM]);
    COV_RX_ACK: cover property (@(posedge pclk)
        st_q == RAAT_RX_SEND_ACK);
endmodule

/* File: tb/raat_air_peer.sv */
// Remote transceiver seen through the modem events of the block.
// Assumes pulses are sampled on pclk and qualifiers are valid with rx_end.
`timescale 1ns/1ps
module raat_air_peer
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tx_start,
    input wire logic rx_mode,
    input wire logic [1:0] ack_mode,
    input wire logic send_pkt,
    input wire logic pkt_repeat,
    input wire logic [39:0] pkt_addr,
    output logic tx_done_air,
    output logic addr_match,
    output logic rx_end,
    output logic [39:0] rx_addr,
    output logic rx_crc_ok,
    output logic rx_has_payload,
    output logic rx_is_repeat,
    output logic rx_skip_ack
);
    int air_q;
    int ack_q;
    logic tgl_q;
    // ============================================================
    // Qualifiers are junk outside rx_end so stale values never help
    assign rx_addr = rx_end ? pkt_addr : ~pkt_addr;
    assign rx_crc_ok = rx_end | tgl_q;
    assign rx_has_payload = rx_end ? (ack_mode == 2'd2) : tgl_q;
    assign rx_is_repeat = rx_end ? pkt_repeat : tgl_q;
    assign rx_skip_ack = rx_end ? 1'b0 : tgl_q;
    // ============================================================
    // Air time, turnaround and answer
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            air_q <= 0;
            ack_q <= 0;
            tgl_q <= 1'b0;
            tx_done_air <= 1'b0;
            addr_match <= 1'b0;
            rx_end <= 1'b0;
        end
        else
        begin
            tgl_q <= ~tgl_q;
            tx_done_air <= 1'b0;
            addr_match <= 1'b0;
            rx_end <= 1'b0;
            if (tx_start)
                air_q <= 40;
            else if (air_q > 1)
                air_q <= air_q - 1;
            else if (air_q == 1)
            begin
                air_q <= 0;
                tx_done_air <= 1'b1;
                if (ack_mode != 2'd0)
                    ack_q <= 80;
            end
            if (send_pkt)
                ack_q <= 80;
            else if (ack_q > 1)
            begin
                ack_q <= ack_q - 1;
                if (ack_q == 30 && rx_mode)
                    addr_match <= 1'b1;
            end
            else if (ack_q == 1)
            begin
                ack_q <= 0;
                rx_end <= rx_mode;
            end
        end
    end
endmodule

/* File: tb/raat_fsm_tb_top.sv */
// Self-checking bench: APB master, transmit and receive transactions.
// Assumes raat_pkg constants and the remote peer model.
`timescale 1ns/1ps
module raat_fsm_tb_top
    import raat_pkg::*;
    ;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r, seed;
    logic tx_fifo_empty, tx_skip_ack, tx_done_air, addr_match, rx_end;
    logic rx_crc_ok, rx_has_payload, rx_is_repeat, rx_skip_ack;
    logic tx_start, tx_fifo_pop, rx_fifo_push, rx_mode, radio_interrupt;
    logic crc_enable, crc_two_bytes, send_pkt, pkt_repeat, rx_seen;
    logic [39:0] rx_addr, tx_dest_addr, pkt_addr;
    logic [2:0] rx_pipe;
    logic [1:0] ack_mode;
    int fail_count, checked, starts, pops, pushes, irqs, pending;
    int cyc, done_cyc, gap, s0, p0;
    assign tx_fifo_empty = (pending == 0);
    raat_fsm DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tx_fifo_empty(tx_fifo_empty),
        .tx_skip_ack(tx_skip_ack), .tx_done_air(tx_done_air),
        .addr_match(addr_match), .rx_addr(rx_addr), .rx_end(rx_end),
        .rx_crc_ok(rx_crc_ok), .rx_has_payload(rx_has_payload),
        .rx_is_repeat(rx_is_repeat), .rx_skip_ack(rx_skip_ack),
        .tx_start(tx_start), .tx_dest_addr(tx_dest_addr),
        .tx_fifo_pop(tx_fifo_pop), .rx_fifo_push(rx_fifo_push),
        .rx_pipe(rx_pipe), .rx_mode(rx_mode), .crc_enable(crc_enable),
        .crc_two_bytes(crc_two_bytes), .radio_interrupt(radio_interrupt));
    raat_air_peer peer (.pclk(pclk), .presetn(presetn), .tx_start(tx_start),
        .rx_mode(rx_mode), .ack_mode(ack_mode), .send_pkt(send_pkt),
        .pkt_repeat(pkt_repeat), .pkt_addr(pkt_addr),
        .tx_done_air(tx_done_air), .addr_match(addr_match), .rx_end(rx_end),
        .rx_addr(rx_addr), .rx_crc_ok(rx_crc_ok),
        .rx_has_payload(rx_has_payload), .rx_is_repeat(rx_is_repeat),
        .rx_skip_ack(rx_skip_ack));
    // ============================================================
    // Helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
    endfunction
    function automatic logic [2:0] flags(input logic d, rd, l);
        return {l, rd, d};
    endfunction
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 100);
        if (pready !== 1'b1)
            chk(40'h0, 40'h1);
        chk(40'(pslverr), 40'h0);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_for(input bit use_irq, input int tgt, input int lim);
        int n;
        n = 0;
        while ((use_irq ? irqs : starts) < tgt && n < lim)
        begin
            @(negedge pclk);
            n++;
        end
        if (n >= lim)
            chk(40'h0, 40'h1);
    endtask
    task automatic print_verdict;
        if (fail_count == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // ============================================================
    // Event counters
    always @(posedge pclk)
    begin
        cyc++;
        if (tx_start === 1'b1)
        begin
            starts++;
            gap = cyc - done_cyc;
        end
        if (tx_done_air === 1'b1)
            done_cyc = cyc;
        if (tx_fifo_pop === 1'b1)
        begin
            pops++;
            pending <= 0;
        end
        if (rx_fifo_push === 1'b1)
            pushes++;
        if (radio_interrupt === 1'b1)
            irqs++;
        if (rx_mode === 1'b1)
            rx_seen = 1'b1;
    end
    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    // Long enough for every transaction, short of a hang
    initial
    begin
        repeat (95000) @(posedge pclk);
        fail_count++;
        print_verdict();
    end
    // ============================================================
    // Main sequence
    initial
    begin
        {presetn, psel, penable, pwrite, tx_skip_ack, send_pkt} = '0;
        {paddr, pwdata, ack_mode, pkt_repeat} = '0;
        seed = 32'h86866a47;
        seed = lfsr(seed);
        pkt_addr = {seed[7:0], lfsr(seed)};
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ADDR_PIPE_EN, 32'h0);
        chk(40'(r), 40'(PIPE_EN_RST));
        apb(1'b0, ADDR_RETRY, 32'h0);
        chk(40'(r), 40'({RETRY_DELAY_RST, RETRY_LIMIT_RST}));
        apb(1'b1, 12'h0f0, 32'hffffffff);
        apb(1'b0, 12'h0f0, 32'h0);
        chk(40'(r), 40'h0);
        apb(1'b1, ADDR_P0_LO, pkt_addr[31:0]);
        apb(1'b1, ADDR_P0_HI, {24'h0, pkt_addr[39:32]});
        // Empty ack, ack with payload, then skip-ack send
        for (int i = 0; i < 3; i++)
        begin
            ack_mode <= (i == 2) ? 2'd0 : 2'(i + 1);
            tx_skip_ack <= (i == 2);
            pending <= 1;
            rx_seen = 1'b0;
            apb(1'b1, ADDR_CTRL, 32'h5);
            wait_for(1'b1, irqs + 1, 20000);
            chk(40'(pops), 40'(i + 1));
            chk(40'(rx_seen), 40'(i != 2));
            chk(tx_dest_addr, pkt_addr);
            repeat (10) @(posedge pclk);
            apb(1'b0, ADDR_STATUS, 32'h0);
            chk(40'(r[2:0]), 40'(flags(1'b1, i == 1, 1'b0)));
            chk(40'(r[10:7]), 40'(RAAT_STBY2));
            apb(1'b1, ADDR_STATUS, 32'h7);
            apb(1'b1, ADDR_CTRL, 32'h4);
        end
        // No answer at all: one retry, then give up
        apb(1'b1, ADDR_RETRY, 32'h1);
        ack_mode <= 2'd0;
        tx_skip_ack <= 1'b0;
        pending <= 1;
        s0 = starts;
        apb(1'b1, ADDR_CTRL, 32'h5);
        wait_for(1'b1, irqs + 1, 40000);
        chk(40'(starts - s0), 40'h2);
        chk(40'(gap >= RETRY_STEP_CYC && gap <= RETRY_STEP_CYC + 8),
            40'h1);
        chk(40'(pops), 40'h3);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(40'(r[2:0]), 40'(flags(1'b0, 1'b0, 1'b1)));
        chk(40'(r[6:3]), 40'h1);
        pending <= 0;
        apb(1'b1, ADDR_STATUS, 32'h7);
        apb(1'b1, ADDR_CTRL, 32'h4);
        // Receiver role: new packet, its repeat, then a new packet on pipe 5
        apb(1'b1, ADDR_CTRL, 32'h17);
        repeat (5) @(negedge pclk);
        chk(40'(rx_mode), 40'h1);
        chk(40'({crc_enable, crc_two_bytes}), 40'h3);
        for (int j = 0; j < 3; j++)
        begin
            // Last round: pipe 5 with shared upper bytes, own low byte
            if (j == 2)
            begin
                apb(1'b1, ADDR_P1_HI, pkt_addr[39:8]);
                apb(1'b1, ADDR_LSB, {pkt_addr[7:0] ^ 8'h5a, 24'h0});
                apb(1'b1, ADDR_PIPE_EN, 32'h21);
                pkt_addr <= {pkt_addr[39:8], pkt_addr[7:0] ^ 8'h5a};
            end
            pkt_repeat <= (j == 1);
            p0 = pushes;
            @(posedge pclk);
            send_pkt <= 1'b1;
            @(posedge pclk);
            send_pkt <= 1'b0;
            wait_for(1'b0, starts + 1, 20000);
            chk(40'(pushes - p0), 40'(j != 1));
            chk(tx_dest_addr, pkt_addr);
            chk(40'(rx_pipe), (j == 2) ? 40'h5 : 40'h0);
            repeat (200) @(negedge pclk);
            chk(40'(rx_mode), 40'h1);
        end
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(40'(r[1]), 40'h1);
        print_verdict();
    end
endmodule
